// ===== common/fwdc_pkg.sv
// Purpose: Shared constants and types for the cascaded FIFO array and its system logic
// Assumes: One clock for writer, reader and transfer path
// Notes:   Offsets are byte addresses on the APB side
package fwdc_pkg;
   // ==========================================================================
   // Array shape
   localparam int NLANE      = 2;
   localparam int LANE_W     = 18;
   localparam int NDEV       = 2;
   localparam int DEV_DEPTH  = 2048;
   // ==========================================================================
   // Timing counts in clock cycles
   localparam int FALL_CYC   = 3;
   localparam int SETTLE_CYC = 2;
   localparam int MRST_CYC   = 4;
   // ==========================================================================
   // Register offsets
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_STATUS   = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADDR_PUSH     = 8'h10;
   localparam logic [7:0] ADDR_POP      = 8'h14;
   localparam logic [7:0] ADDR_WDATA    = 8'h20;
   localparam logic [7:0] ADDR_RDATA    = 8'h40;
   // ==========================================================================
   // Field positions and reset values
   localparam int   CTRL_FT_BIT   = 0;
   localparam int   CTRL_MRST_BIT = 1;
   localparam logic CTRL_FT_RST   = 1'b1;
   localparam int   STAT_AVAIL    = 0;
   localparam int   STAT_SPACE    = 1;
   localparam int   STAT_FT       = 2;
   localparam int   STAT_BUSY     = 3;
   localparam int   IRQ_DATA      = 0;
   localparam int   IRQ_SPACE     = 1;
   localparam int   IRQ_OVF       = 2;
   localparam int   IRQ_UNF       = 3;
   localparam int   IRQ_W         = 4;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
   // ==========================================================================
   // Types
   typedef logic [LANE_W-1:0]             fwdc_lane_type;
   typedef logic [NLANE-1:0][LANE_W-1:0]  fwdc_word_type;
endpackage : fwdc_pkg

// ===== common/fwdc_if.sv
// Purpose: Pins between the FIFO array and the system logic that drives it
// Assumes: Flags are active low, one per lane
// Notes:   Classic flags idle high in fall-through mode and the reverse
`timescale 1ns/1ns
interface fwdc_if;
   import fwdc_pkg::*;
   // ==========================================================================
   // Shared control
   logic                  mrst;
   logic                  modeSel;
   logic                  wrEnN;
   logic                  rdEnN;
   // ==========================================================================
   // Data and per-lane flags
   fwdc_word_type         wrData;
   fwdc_word_type         rdData;
   logic [NLANE-1:0]      emptyFlagN;
   logic [NLANE-1:0]      fullIndicatorN;
   logic [NLANE-1:0]      outputReadyN;
   logic [NLANE-1:0]      inputReadyN;

   modport array (
      input  mrst, modeSel, wrEnN, rdEnN, wrData,
      output rdData, emptyFlagN, fullIndicatorN, outputReadyN, inputReadyN
   );
   modport system (
      output mrst, modeSel, wrEnN, rdEnN, wrData,
      input  rdData, emptyFlagN, fullIndicatorN, outputReadyN, inputReadyN
   );
endinterface : fwdc_if

// ===== src/fwdc_array.sv
// Purpose: Lanes side by side, each a chain of FIFO stages, all fall-through except the last stage in classic mode
// Assumes: Writer, reader and transfer path all on mclk
// Notes:   Odd lanes take writes one cycle late, giving the inter-lane flag skew
`timescale 1ns/1ns
module fwdc_array #(
   parameter int DEVS  = fwdc_pkg::NDEV,
   parameter int DEPTH = fwdc_pkg::DEV_DEPTH
)(
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // Array pins
   fwdc_if.array     pins,
   // Local status
   output logic      fallThrough
);
   import fwdc_pkg::*;

   localparam int CW = $clog2(DEPTH + 1);
   localparam int AW = $clog2(DEPTH);
   localparam int TW = $clog2(FALL_CYC);

   logic devRst;
   logic modeFt_reg;

   function automatic logic [AW-1:0] ptrInc(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction : ptrInc

   // ==========================================================================
   // Mode captured during master reset
   assign devRst = rst | pins.mrst;
   always_ff @(posedge mclk) begin
      if (devRst) begin
         modeFt_reg <= pins.modeSel;
      end
   end
   assign fallThrough = modeFt_reg;

   // ==========================================================================
   // Lanes
   for (genvar l = 0; l < NLANE; l++) begin : g_lane
      logic            laneWen;
      fwdc_lane_type   laneDin;
      logic [DEVS-1:0] stWen;
      logic [DEVS-1:0] stPop;
      logic [DEVS-1:0] stValid;
      logic [DEVS-1:0] stFull;
      logic [DEVS-1:0] stHas;
      fwdc_lane_type   stDin [DEVS];
      fwdc_lane_type   stQ   [DEVS];

      // Shared write strobe, skewed on odd lanes
      if (l % 2 == 1) begin : g_skew
         logic          wen_reg;
         fwdc_lane_type din_reg;
         always_ff @(posedge mclk) begin
            if (devRst) begin
               wen_reg <= 1'b0;
               din_reg <= '0;
            end else begin
               wen_reg <= !pins.wrEnN;
               din_reg <= pins.wrData[l];
            end
         end
         assign laneWen = wen_reg;
         assign laneDin = din_reg;
      end else begin : g_direct
         assign laneWen = !pins.wrEnN;
         assign laneDin = pins.wrData[l];
      end

      for (genvar s = 0; s < DEVS; s++) begin : g_stage
         fwdc_lane_type  mem [DEPTH];
         logic [AW-1:0]  wptr_reg;
         logic [AW-1:0]  rptr_reg;
         logic [CW-1:0]  cnt_reg;
         logic [TW-1:0]  tmr_reg;
         logic           valid_reg;
         fwdc_lane_type  q_reg;
         logic           ftStage;
         logic           take;
         logic           load;

         if (s == 0) begin : g_head
            assign stWen[s] = laneWen;
            assign stDin[s] = laneDin;
         end else begin : g_link
            assign stWen[s] = stValid[s-1] & !stFull[s];
            assign stDin[s] = stQ[s-1];
         end
         if (s == DEVS - 1) begin : g_tail
            assign stPop[s] = !pins.rdEnN & (modeFt_reg ? valid_reg : stHas[s]);
         end else begin : g_mid
            assign stPop[s] = stWen[s+1];
         end

         assign ftStage = modeFt_reg || (s != DEVS - 1);
         assign take    = stWen[s] & !stFull[s];
         assign load    = stHas[s] & (ftStage
                        ? ((valid_reg & stPop[s]) |
                           (!valid_reg & (tmr_reg == TW'(FALL_CYC - 1))))
                        : stPop[s]);

         // Fall-through delay, only while the output stage is empty
         always_ff @(posedge mclk) begin
            if (devRst) begin
               tmr_reg <= '0;
            end else if (ftStage && stHas[s] && !valid_reg &&
                         tmr_reg != TW'(FALL_CYC - 1)) begin
               tmr_reg <= TW'(tmr_reg + 1'b1);
            end else begin
               tmr_reg <= '0;
            end
         end

         // Storage pointers and fill
         always_ff @(posedge mclk) begin
            if (devRst) begin
               wptr_reg <= '0;
               rptr_reg <= '0;
               cnt_reg  <= '0;
            end else begin
               if (take) begin
                  wptr_reg <= ptrInc(wptr_reg);
               end
               if (load) begin
                  rptr_reg <= ptrInc(rptr_reg);
               end
               cnt_reg <= CW'(cnt_reg + CW'(take) - CW'(load));
            end
         end

         always_ff @(posedge mclk) begin
            if (take) begin
               mem[wptr_reg] <= stDin[s];
            end
         end

         // Output register
         always_ff @(posedge mclk) begin
            if (devRst) begin
               valid_reg <= 1'b0;
               q_reg     <= '0;
            end else if (load) begin
               valid_reg <= 1'b1;
               q_reg     <= mem[rptr_reg];
            end else if (ftStage && stPop[s]) begin
               valid_reg <= 1'b0;
            end
         end

         assign stValid[s] = valid_reg;
         assign stFull[s]  = (cnt_reg == CW'(DEPTH));
         assign stHas[s]   = (cnt_reg != '0);
         assign stQ[s]     = q_reg;
      end

      // Lane pins
      assign pins.rdData[l]         = stQ[DEVS-1];
      assign pins.outputReadyN[l]   = modeFt_reg ? !stValid[DEVS-1] : 1'b1;
      assign pins.inputReadyN[l]    = modeFt_reg ? stFull[0] : 1'b1;
      assign pins.emptyFlagN[l]     = modeFt_reg ? 1'b1 : stHas[DEVS-1];
      assign pins.fullIndicatorN[l] = modeFt_reg ? 1'b1 : !stFull[0];
   end
endmodule : fwdc_array

// ===== src/fwdc_system.sv
// Purpose: System logic writing and reading the FIFO array, with an APB register file
// Assumes: Array and this block share mclk, which also serves as transfer clock
// Notes:   Zero wait state APB slave; read data registered in the setup cycle
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
module fwdc_system (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         rst,
   // APB slave
   input  wire logic [7:0]   paddr,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [31:0]  pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   // Interrupt
   output logic              irq,
   // Array pins
   fwdc_if.system            pins
);
   import fwdc_pkg::*;

   localparam int MW = $clog2(MRST_CYC + 1);
   localparam int SW = $clog2(SETTLE_CYC + 1);

   logic                ctrlFt_reg;
   logic                ftApplied_reg;
   logic [MW-1:0]       mrstCnt_reg;
   logic [SW-1:0]       settle_reg;
   logic                wenPulse_reg;
   logic                renPulse_reg;
   logic                capPend_reg;
   fwdc_word_type       wrWord_reg;
   fwdc_word_type       rdWord_reg;
   logic [IRQ_W-1:0]    irqStat_reg;
   logic [IRQ_W-1:0]    irqMask_reg;
   logic [IRQ_W-1:0]    irqSet;
   logic [IRQ_W-1:0]    irqClr;
   logic                outAvail;
   logic                inSpace;
   logic                outAvail_reg;
   logic                inSpace_reg;
   logic                idle;
   logic                access;
   logic                wrAcc;
   logic                pushReq;
   logic                popReq;
   logic                pushOk;
   logic                popOk;
   logic [31:0]         rdMux;
   logic [31:0]         prdata_reg;

   function automatic logic inWin(input logic [7:0] a, input logic [7:0] base);
      return (a >= base) && (a < 8'(base + 8'(4 * NLANE))) && (a[1:0] == 2'h0);
   endfunction : inWin

   function automatic int laneOf(input logic [7:0] a, input logic [7:0] base);
      return int'(8'(a - base) >> 2);
   endfunction : laneOf

   function automatic logic mapped(input logic [7:0] a);
      return (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_IRQ_STAT) ||
             (a == ADDR_IRQ_MASK) || (a == ADDR_PUSH) || (a == ADDR_POP) ||
             inWin(a, ADDR_WDATA) || inWin(a, ADDR_RDATA);
   endfunction : mapped

   // ==========================================================================
   // Bus decode
   assign access  = psel & penable;
   assign pready  = access;
   assign pslverr = access & !mapped(paddr);
   assign wrAcc   = access & pwrite;
   assign pushReq = wrAcc & (paddr == ADDR_PUSH);
   assign popReq  = wrAcc & (paddr == ADDR_POP);
   assign prdata  = prdata_reg;

   // ==========================================================================
   // Composite flags through gates
   assign outAvail = ftApplied_reg ? !(|pins.outputReadyN)
                                   : (&pins.emptyFlagN);
   assign inSpace  = ftApplied_reg ? !(|pins.inputReadyN)
                                   : (&pins.fullIndicatorN);
   assign idle     = (settle_reg == '0) && (mrstCnt_reg == '0) && !capPend_reg;
   assign pushOk   = pushReq & idle & inSpace;
   assign popOk    = popReq & idle & outAvail;

   // ==========================================================================
   // Control and master reset
   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrlFt_reg  <= CTRL_FT_RST;
         mrstCnt_reg <= '0;
      end else begin
         if (wrAcc && paddr == ADDR_CTRL) begin
            ctrlFt_reg <= pwdata[CTRL_FT_BIT];
         end
         if (wrAcc && paddr == ADDR_CTRL && pwdata[CTRL_MRST_BIT]) begin
            mrstCnt_reg <= MW'(MRST_CYC);
         end else if (mrstCnt_reg != '0) begin
            mrstCnt_reg <= MW'(mrstCnt_reg - 1'b1);
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ftApplied_reg <= CTRL_FT_RST;
      end else if (pins.mrst) begin
         ftApplied_reg <= ctrlFt_reg;
      end
   end

   assign pins.mrst    = (mrstCnt_reg != '0);
   assign pins.modeSel = rst ? CTRL_FT_RST : ctrlFt_reg;

   // ==========================================================================
   // Push and pop strobes
   always_ff @(posedge mclk) begin
      if (rst) begin
         wenPulse_reg <= 1'b0;
         renPulse_reg <= 1'b0;
         capPend_reg  <= 1'b0;
         settle_reg   <= '0;
      end else begin
         wenPulse_reg <= pushOk;
         renPulse_reg <= popOk;
         capPend_reg  <= renPulse_reg & !ftApplied_reg;
         if (pushOk || popOk) begin
            settle_reg <= SW'(SETTLE_CYC);
         end else if (settle_reg != '0) begin
            settle_reg <= SW'(settle_reg - 1'b1);
         end
      end
   end

   assign pins.wrEnN  = !wenPulse_reg;
   assign pins.rdEnN  = !renPulse_reg;
   assign pins.wrData = wrWord_reg;

   // ==========================================================================
   // Lane data registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         wrWord_reg <= '0;
         rdWord_reg <= '0;
      end else begin
         if (wrAcc && inWin(paddr, ADDR_WDATA)) begin
            wrWord_reg[laneOf(paddr, ADDR_WDATA)] <= pwdata[LANE_W-1:0];
         end
         if (popOk && ftApplied_reg) begin
            rdWord_reg <= pins.rdData;
         end else if (capPend_reg) begin
            rdWord_reg <= pins.rdData;
         end
      end
   end

   // ==========================================================================
   // Interrupts
   assign irqSet[IRQ_DATA]  = outAvail & !outAvail_reg;
   assign irqSet[IRQ_SPACE] = inSpace & !inSpace_reg;
   assign irqSet[IRQ_OVF]   = pushReq & !pushOk;
   assign irqSet[IRQ_UNF]   = popReq & !popOk;
   assign irqClr = (wrAcc && paddr == ADDR_IRQ_STAT) ? pwdata[IRQ_W-1:0] : '0;

   always_ff @(posedge mclk) begin
      if (rst) begin
         outAvail_reg <= 1'b0;
         inSpace_reg  <= 1'b0;
         irqStat_reg  <= '0;
         irqMask_reg  <= IRQ_MASK_RST;
      end else begin
         outAvail_reg <= outAvail;
         inSpace_reg  <= inSpace;
         irqStat_reg  <= (irqStat_reg & ~irqClr) | irqSet;
         if (wrAcc && paddr == ADDR_IRQ_MASK) begin
            irqMask_reg <= pwdata[IRQ_W-1:0];
         end
      end
   end

   assign irq = |(irqStat_reg & irqMask_reg);

   // ==========================================================================
   // Read back
   always_comb begin
      rdMux = 32'h00000000;
      if (paddr == ADDR_CTRL) begin
         rdMux[CTRL_FT_BIT]   = ctrlFt_reg;
         rdMux[CTRL_MRST_BIT] = pins.mrst;
      end else if (paddr == ADDR_STATUS) begin
         rdMux[STAT_AVAIL] = outAvail;
         rdMux[STAT_SPACE] = inSpace;
         rdMux[STAT_FT]    = ftApplied_reg;
         rdMux[STAT_BUSY]  = !idle;
      end else if (paddr == ADDR_IRQ_STAT) begin
         rdMux[IRQ_W-1:0] = irqStat_reg;
      end else if (paddr == ADDR_IRQ_MASK) begin
         rdMux[IRQ_W-1:0] = irqMask_reg;
      end else if (inWin(paddr, ADDR_WDATA)) begin
         rdMux[LANE_W-1:0] = wrWord_reg[laneOf(paddr, ADDR_WDATA)];
      end else if (inWin(paddr, ADDR_RDATA)) begin
         rdMux[LANE_W-1:0] = rdWord_reg[laneOf(paddr, ADDR_RDATA)];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         prdata_reg <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata_reg <= rdMux;
      end
   end
endmodule : fwdc_system

// ===== testbench/fwdc_props.sv
// Purpose: Assertions on the pins between the FIFO array and the system logic
// Assumes: Lane 0 leads, lane 1 follows one edge later
// Notes:   Lane 0 occupancy and write idle time kept in helper logic
`timescale 1ns/1ns
module fwdc_props #(
   parameter int DEVS  = fwdc_pkg::NDEV,
   parameter int DEPTH = fwdc_pkg::DEV_DEPTH
)(
   // Clock and reset
   input wire logic                    mclk,
   input wire logic                    rst,
   // Shared control
   input wire logic                    mrst,
   input wire logic                    modeSel,
   input wire logic                    wrEnN,
   input wire logic                    rdEnN,
   // Data and flags
   input wire fwdc_pkg::fwdc_word_type wrData,
   input wire fwdc_pkg::fwdc_word_type rdData,
   input wire logic [1:0]              emptyFlagN,
   input wire logic [1:0]              fullIndicatorN,
   input wire logic [1:0]              outputReadyN,
   input wire logic [1:0]              inputReadyN
);
   import fwdc_pkg::*;
   localparam int CAP = DEVS * (DEPTH + 1);
   logic ftReg;
   int   occ;
   int   idle;
   // ==========================================================================
   // Helper logic
   always_ff @(posedge mclk) begin
      if (rst || mrst) ftReg <= modeSel;
   end
   always_ff @(posedge mclk) begin
      if (rst || mrst) occ <= 0;
      else occ <= occ + int'(!wrEnN && !inputReadyN[0]) - int'(!rdEnN && !outputReadyN[0]);
   end
   always_ff @(posedge mclk) begin
      if (rst || !wrEnN) idle <= (rst ? 15 : 0);
      else if (idle < 15) idle <= idle + 1;
   end
   // ==========================================================================
   // Properties
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst || mrst);
   sequence s_wr_empty;
      ftReg && occ == 0 && !wrEnN && !inputReadyN[0];
   endsequence
   sequence s_ripple;
      outputReadyN[0] [*8] ##1 !outputReadyN[0];
   endsequence
   a_ripple_delay: assert property (s_wr_empty |-> s_ripple)
      else $error("first word ripple time wrong");
   a_lane_skew: assert property (s_wr_empty |-> ##8 outputReadyN[1] ##1 !outputReadyN[1])
      else $error("second lane ready skew wrong");
   a_first_word: assert property (s_wr_empty |-> ##8 rdData[0] == $past(wrData[0], 8))
      else $error("first word data wrong at chain output");
   a_empty_idle: assert property (ftReg && occ == 0 |-> outputReadyN[0])
      else $error("output ready with empty chain");
   a_full_refuse: assert property (ftReg && occ == CAP |-> inputReadyN[0])
      else $error("input ready with full chain");
   a_bubble_up: assert property (ftReg && occ == CAP && !rdEnN && !outputReadyN[0]
      |-> ##[1:16] !inputReadyN[0])
      else $error("freed location did not reach first stage");
   a_no_extra: assert property (ftReg && idle == 15 && occ >= 2 && !rdEnN
      && !outputReadyN[0] |=> !outputReadyN[0])
      else $error("later word delayed");
   a_data_hold: assert property (ftReg && !outputReadyN[0] && rdEnN |=> $stable(rdData[0]))
      else $error("output word changed without read");
   a_mode_flags: assert property (ftReg ? (&emptyFlagN && &fullIndicatorN)
      : (&outputReadyN && &inputReadyN))
      else $error("flags of unused mode active");
   a_read_ready: assert property (ftReg && !rdEnN |-> ~|outputReadyN)
      else $error("read without composite output ready");
   a_write_space: assert property (ftReg && !wrEnN |-> ~|inputReadyN)
      else $error("write without composite input ready");
   a_wr_pulse: assert property (!wrEnN |=> wrEnN)
      else $error("write strobe longer than one cycle");
   a_rd_pulse: assert property ($fell(rdEnN) |=> $rose(rdEnN))
      else $error("read strobe longer than one cycle");
endmodule : fwdc_props

// ===== testbench/testbench.sv
// Purpose: Self-checking bench for the FIFO array and its system logic
// Assumes: Stages of depth 4 so fill and drain stay short
// Notes:   Expected words kept in a queue model
`timescale 1ns/1ns
module testbench;
   import fwdc_pkg::*;
   localparam int DEPTH = 4;
   localparam int CAP   = NDEV * (DEPTH + 1);
   logic        mclk    = 1'b0;
   logic        rst     = 1'b1;
   logic [7:0]  paddr   = 8'h00;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        ftOut;
   logic [31:0] seed    = 32'h0000EE40;
   logic [31:0] rd;
   logic        err;
   logic [35:0] model[$];
   int          badCount = 0;
   int          nChecks  = 0;
   int          cyc      = 0;
   // ==========================================================================
   // Design and checker
   fwdc_if pinsIf ();
   fwdc_array #(.DEVS(NDEV), .DEPTH(DEPTH)) fwdc_array_inst (.mclk(mclk), .rst(rst),
      .pins(pinsIf), .fallThrough(ftOut));
   fwdc_system fwdc_system_inst (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .pins(pinsIf));
   fwdc_props #(.DEVS(NDEV), .DEPTH(DEPTH)) fwdc_props_inst (.mclk(mclk), .rst(rst),
      .mrst(pinsIf.mrst), .modeSel(pinsIf.modeSel), .wrEnN(pinsIf.wrEnN),
      .rdEnN(pinsIf.rdEnN), .wrData(pinsIf.wrData), .rdData(pinsIf.rdData),
      .emptyFlagN(pinsIf.emptyFlagN), .fullIndicatorN(pinsIf.fullIndicatorN),
      .outputReadyN(pinsIf.outputReadyN), .inputReadyN(pinsIf.inputReadyN));
   // ==========================================================================
   // Clock, timeout, helpers
   always #4 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         badCount++;
         finalReport();
      end
   end
   task automatic finalReport();
      if (badCount == 0 && nChecks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finalReport
   task automatic chk(input string name, input logic [35:0] exp, input logic [35:0] got);
      nChecks++;
      if (got !== exp) begin
         badCount++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   function automatic logic [35:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return {seed[3:0], seed};
   endfunction : rnd
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic waitStat(input int b, input logic v);
      int n;
      n = 0;
      do begin
         apb(1'b0, ADDR_STATUS, 32'h0);
         n++;
      end while (rd[b] !== v && n < 60);
      chk("status bit", 36'(v), 36'(rd[b]));
   endtask : waitStat
   task automatic push(input logic [35:0] w);
      waitStat(STAT_SPACE, 1'b1);
      apb(1'b1, ADDR_WDATA, {14'h0, w[17:0]});
      apb(1'b1, ADDR_WDATA + 8'h04, {14'h0, w[35:18]});
      apb(1'b1, ADDR_PUSH, 32'h0);
      @(posedge mclk);
      chk("write strobe", 36'h0, 36'(pinsIf.wrEnN));
      chk("wide write word", w, pinsIf.wrData);
      waitStat(STAT_BUSY, 1'b0);
      model.push_back(w);
   endtask : push
   task automatic pop();
      logic [35:0] exp;
      waitStat(STAT_AVAIL, 1'b1);
      apb(1'b1, ADDR_POP, 32'h0);
      waitStat(STAT_BUSY, 1'b0);
      exp = model.pop_front();
      apb(1'b0, ADDR_RDATA, 32'h0);
      chk("read lane0", {18'h0, exp[17:0]}, {4'h0, rd});
      apb(1'b0, ADDR_RDATA + 8'h04, 32'h0);
      chk("read lane1", {18'h0, exp[35:18]}, {4'h0, rd});
   endtask : pop
   task automatic setMode(input logic ft);
      apb(1'b1, ADDR_CTRL, {30'h0, 1'b1, ft});
      repeat (8) @(posedge mclk);
      chk("applied mode", 36'(ft), 36'(ftOut));
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("status mode", 36'(ft), 36'(rd[STAT_FT]));
   endtask : setMode
   // ==========================================================================
   // Main sequence
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl reset", 36'h1, 36'(rd));
      apb(1'b0, ADDR_IRQ_MASK, 32'h0);
      chk("mask reset", 36'h0, 36'(rd));
      apb(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk("irq status reset", 36'h2, 36'(rd));
      apb(1'b0, 8'h30, 32'h0);
      chk("unmapped error", 36'h1, 36'(err));
      chk("unmapped data", 36'h0, 36'(rd));
      for (int i = 0; i < CAP; i++) push(rnd());
      apb(1'b0, ADDR_WDATA + 8'h04, 32'h0);
      chk("wdata readback", {18'h0, model[CAP-1][35:18]}, {4'h0, rd});
      repeat (40) @(posedge mclk);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("full chain space", 36'h0, 36'(rd[STAT_SPACE]));
      apb(1'b1, ADDR_PUSH, 32'h0);
      apb(1'b1, ADDR_IRQ_MASK, 32'h4);
      @(posedge mclk);
      chk("overflow irq", 36'h1, 36'(irq));
      apb(1'b1, ADDR_IRQ_STAT, 32'hF);
      @(posedge mclk);
      chk("irq cleared", 36'h0, 36'(irq));
      while (model.size() > 0) pop();
      apb(1'b1, ADDR_POP, 32'h0);
      apb(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk("underflow flag", 36'h1, 36'(rd[IRQ_UNF]));
      chk("masked irq", 36'h0, 36'(irq));
      setMode(1'b0);
      for (int i = 0; i < 3; i++) push(rnd());
      for (int i = 0; i < 3; i++) pop();
      setMode(1'b1);
      apb(1'b1, ADDR_IRQ_STAT, 32'h1);
      push(rnd());
      pop();
      apb(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk("data ready irq", 36'h1, 36'(rd[IRQ_DATA]));
      finalReport();
   end
endmodule : testbench
